// ### design/frame_seq_pkg.sv
// shared constants, command codes, states and pin bundles of the
// linear array frame sequencer; assumes a 20 MHz core clock
package frame_seq_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_TIME_NS = 10000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_TIME_NS = 20000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam logic [15:0] ZEBRA_INT_TICKS = 16'h0010;

  // command frame layout
  localparam int CMD_BITS = 24;
  localparam int OP_MSB = 23;
  localparam int OP_LSB = 16;
  localparam int ARG_MSB = 15;
  localparam int THR_LSB = 8;
  localparam int RES8_POS = 8;

  // first command byte; zebra codes fixed, the others arbitrary
  localparam logic [7:0] CHIP_RESET_COMMAND = 8'hF0;
  localparam logic [7:0] START_INT_COMMAND = 8'hB8;
  localparam logic [7:0] WRITE_THRESHOLD_COMMAND = 8'hD2;
  localparam logic [7:0] READ_OUT_COMMAND = 8'h99;
  localparam logic [7:0] ZEBRA_ODD_HIGH_COMMAND = 8'hE8;
  localparam logic [7:0] ZEBRA_EVEN_HIGH_COMMAND = 8'hE4;
  localparam logic [7:0] ZEBRA_ALL_HIGH_COMMAND = 8'hE2;
  localparam logic [7:0] ZEBRA_ALL_LOW_COMMAND = 8'hE1;

  // read-out frame
  localparam int FRAME_BYTES = 20;
  localparam logic [7:0] TEMP_BYTE_IDX = 8'h06;
  localparam logic [7:0] DARK_CODE = 8'h10;
  localparam logic [7:0] IDLE_FILL = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_WAIT_CR = 3'b001,
    ST_IDLE = 3'b010,
    ST_INTEG = 3'b011,
    ST_CONVERT = 3'b100,
    ST_READY = 3'b101,
    ST_READOUT = 3'b110
  } seq_state_e;

  typedef enum logic [2:0] {
    ZB_OFF = 3'b000,
    ZB_ODD = 3'b001,
    ZB_EVEN = 3'b010,
    ZB_ALL_HIGH = 3'b011,
    ZB_ALL_LOW = 3'b100
  } zebra_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_pins_s;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } spi_drive_s;

endpackage

// ### design/frame_byte_buffer.sv
// small fifo between frame byte assembly and the serial shifter
// assumes both sides on the same clock; flush drops all entries
`timescale 1ns/1ps
module frame_byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("frame_byte_buffer: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } buf_st_s;

  buf_st_s q, d;
  logic push;
  logic pop;

  assign in_ready_o = q.count != (PW + 1)'(DEPTH);
  assign out_valid_o = q.count != '0;
  assign out_data_o = q.mem[q.rd_ptr];

  always_comb begin
    d = q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wr_ptr] = in_data_i;
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      d.count = q.count + 1'b1;
    end else if (pop && !push) begin
      d.count = q.count - 1'b1;
    end
    if (flush_i) begin
      d.wr_ptr = '0;
      d.rd_ptr = '0;
      d.count = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) q.count <= (PW + 1)'(DEPTH))
    else $error("buffer count beyond depth");

endmodule

// ### design/frame_sequencer.sv
// frame cycle sequencer of a serially commanded linear sensor array
// assumes serial pins arrive asynchronously and pixel/temperature
// codes come from converter logic on core_clk_i
//
// What this block does
// [RL1] 8-bit read-out puts temperature in byte 6
// [RL2] power-on reset phase before any command
// [RL3] host sends chip reset first
// [RL4] start-integration command begins integration
// [RL5] conversion wait before frame-ready rises
// [RL6] host reads only while frame-ready high
// [RL7] host starts integration after read-out completes; block also accepts a start in ready before read-out
// [RL8] host writes thresholds before next integration
// [RL9] first frame after reset is dummy
// [RL10] zebra commands run same frame cycle
// [RL11] frame-ready may serve as host interrupt
// [RL12] zebra integration starts at chip-select high
// [RL13] all-low zebra temperature byte reads dark
// [RL14] new start drops frame-ready low
`timescale 1ns/1ps
module frame_sequencer #(
  parameter int POR_CYC = frame_seq_pkg::POR_CYCLES,
  parameter int CONV_CYC = frame_seq_pkg::CONV_CYCLES,
  parameter int TICK_CYC = frame_seq_pkg::TICK_CYCLES,
  parameter int FRAME_LEN = frame_seq_pkg::FRAME_BYTES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serial link pins
  input wire frame_seq_pkg::spi_pins_s spi_pins_i,
  output frame_seq_pkg::spi_drive_s spi_drive_o,
  // converter side
  input wire logic [7:0] pixel_data_i,
  input wire logic pixel_valid_i,
  output logic pixel_ready_o,
  input wire logic [7:0] temp_code_i,
  // sensor control and status
  output logic frame_available_o,
  output logic integrate_o,
  output frame_seq_pkg::zebra_e zebra_pattern_o,
  output logic [7:0] threshold_o,
  output logic dummy_scan_o
);
  import frame_seq_pkg::*;

  if (POR_CYC < 1 || POR_CYC > 65535 || CONV_CYC < 1 ||
      CONV_CYC > 65535 || TICK_CYC < 1 || TICK_CYC > 31 ||
      FRAME_LEN <= 6 || FRAME_LEN > 255) begin : g_bad
    $error("frame_sequencer: parameter out of range");
  end

  typedef struct packed {
    spi_pins_s sync1;
    spi_pins_s sync2;
    spi_pins_s prev;
    logic [CMD_BITS-1:0] shift_in;
    logic [4:0] rx_bits;
    seq_state_e st;
    zebra_e zebra;
    logic res8;
    logic dummy;
    logic [7:0] thr;
    logic [15:0] int_ticks;
    logic [4:0] div;
    logic [15:0] cnt;
    logic [7:0] byte_idx;
    logic [7:0] temp;
    logic [7:0] tx_sr;
    logic [2:0] tx_bits;
    logic frame_rdy;
    logic integ;
  } seq_st_s;

  function automatic zebra_e decode_zebra(input logic [7:0] op);
    zebra_e z;
    z = ZB_OFF;
    if (op == ZEBRA_ODD_HIGH_COMMAND) begin
      z = ZB_ODD;
    end else if (op == ZEBRA_EVEN_HIGH_COMMAND) begin
      z = ZB_EVEN;
    end else if (op == ZEBRA_ALL_HIGH_COMMAND) begin
      z = ZB_ALL_HIGH;
    end else if (op == ZEBRA_ALL_LOW_COMMAND) begin
      z = ZB_ALL_LOW;
    end
    return z;
  endfunction

  seq_st_s q, d;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, tick;
  logic cmd_done, can_start, start_evt, temp_slot, gen_active;
  logic fill_valid, fill_ready, drain_valid, drain_ready, flush;
  logic [7:0] op, fill_data, drain_data;
  zebra_e zb_code;

  ///////////////////////////////////////////////////////////////////////
  // pin edges and command framing

  assign sclk_rise = q.sync2.sclk && !q.prev.sclk;
  assign sclk_fall = !q.sync2.sclk && q.prev.sclk;
  assign cs_rise = q.sync2.cs_n && !q.prev.cs_n;
  assign cs_fall = !q.sync2.cs_n && q.prev.cs_n;
  assign tick = q.div == 5'(TICK_CYC - 1);
  assign op = q.shift_in[OP_MSB:OP_LSB];
  assign zb_code = decode_zebra(op);
  // commands only take effect once the whole frame is in and cs rises
  assign cmd_done = cs_rise && q.rx_bits == 5'(CMD_BITS) &&
                    q.st != ST_READOUT;
  assign can_start = q.st == ST_IDLE || q.st == ST_READY; // RL7
  assign start_evt = cmd_done && can_start &&
                     (op == START_INT_COMMAND || zb_code != ZB_OFF);

  ///////////////////////////////////////////////////////////////////////
  // read-out byte assembly

  assign gen_active = q.st == ST_READOUT &&
                      q.byte_idx < 8'(FRAME_LEN);
  assign temp_slot = q.res8 && q.byte_idx == TEMP_BYTE_IDX; // RL1
  assign fill_valid = gen_active && (temp_slot || pixel_valid_i);
  assign pixel_ready_o = gen_active && !temp_slot && fill_ready;
  assign flush = q.st != ST_READOUT;

  always_comb begin
    if (!temp_slot) begin
      fill_data = pixel_data_i;
    end else if (q.zebra == ZB_ALL_LOW) begin
      fill_data = DARK_CODE; // RL13
    end else begin
      fill_data = q.temp; // RL1
    end
  end

  // shifter pulls a byte at cs fall and after each eighth falling edge
  assign drain_ready = q.st == ST_READOUT && !q.sync2.cs_n &&
                       (cs_fall || (sclk_fall && q.tx_bits == 3'h7));

  frame_byte_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_buf (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .in_valid_i(fill_valid),
    .in_ready_o(fill_ready),
    .in_data_i(fill_data),
    .out_valid_o(drain_valid),
    .out_ready_i(drain_ready),
    .out_data_o(drain_data)
  );

  ///////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.sync1 = spi_pins_i;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    d.div = tick ? 5'h00 : q.div + 5'h01;

    if (cs_fall) begin
      d.rx_bits = 5'h00;
    end else if (!q.sync2.cs_n && sclk_rise && q.st != ST_READOUT) begin
      d.shift_in = {q.shift_in[CMD_BITS-2:0], q.sync2.mosi};
      if (q.rx_bits != 5'h1F) begin
        d.rx_bits = q.rx_bits + 5'h01;
      end
    end

    if (fill_valid && fill_ready) begin
      d.byte_idx = q.byte_idx + 8'h01;
    end
    if (drain_ready) begin
      // underrun sends filler rather than stalling the host clock
      d.tx_sr = drain_valid ? drain_data : IDLE_FILL;
      d.tx_bits = 3'h0;
    end else if (sclk_fall && !q.sync2.cs_n) begin
      d.tx_sr = {q.tx_sr[6:0], 1'b0};
      d.tx_bits = q.tx_bits + 3'h1;
    end

    case (q.st)
      ST_POR: begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(POR_CYC - 1)) begin
          d.st = ST_WAIT_CR; // RL2
          d.cnt = 16'h0000;
        end
      end
      ST_WAIT_CR: begin
        d.cnt = 16'h0000;
      end
      ST_IDLE, ST_READY: begin
        if (cmd_done && op == WRITE_THRESHOLD_COMMAND) begin
          d.thr = q.shift_in[ARG_MSB:THR_LSB]; // RL8
        end else if (cmd_done && op == READ_OUT_COMMAND &&
                     q.st == ST_READY) begin
          d.st = ST_READOUT; // RL6
          d.res8 = q.shift_in[RES8_POS];
          d.byte_idx = 8'h00;
          d.temp = temp_code_i; // RL1
        end else if (start_evt) begin
          d.st = ST_INTEG; // RL4
          d.integ = 1'b1;
          d.frame_rdy = 1'b0; // RL14
          d.cnt = 16'h0000;
          d.zebra = zb_code; // RL10
          if (zb_code != ZB_OFF) begin
            d.int_ticks = ZEBRA_INT_TICKS; // RL12
          end else if (q.shift_in[ARG_MSB:0] == 16'h0000) begin
            d.int_ticks = 16'h0001;
          end else begin
            d.int_ticks = q.shift_in[ARG_MSB:0];
          end
        end
      end
      ST_INTEG: begin
        if (tick) begin
          d.cnt = q.cnt + 16'h0001;
          if (q.cnt == q.int_ticks - 16'h0001) begin
            d.st = ST_CONVERT;
            d.integ = 1'b0;
            d.cnt = 16'h0000;
          end
        end
      end
      ST_CONVERT: begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(CONV_CYC - 1)) begin
          d.st = ST_READY; // RL5
          d.frame_rdy = 1'b1; // RL11
        end
      end
      ST_READOUT: begin
        if (cs_rise) begin
          d.st = ST_IDLE;
          d.frame_rdy = 1'b0;
          d.dummy = 1'b0; // RL9
        end
      end
      default: begin
        d.st = ST_POR;
      end
    endcase

    // chip reset is honoured in every state except read-out once power-on reset ends
    if (cmd_done && op == CHIP_RESET_COMMAND && q.st != ST_POR) begin
      d.st = ST_IDLE; // RL3
      d.integ = 1'b0;
      d.frame_rdy = 1'b0;
      d.zebra = ZB_OFF;
      d.thr = THRESHOLD_RESET;
      d.dummy = 1'b1; // RL9
      d.cnt = 16'h0000;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: ST_POR, zebra: ZB_OFF, sync1: 3'b010, sync2: 3'b010,
             prev: 3'b010, dummy: 1'b1, default: '0}; // RL2
    end else begin
      q <= d;
    end
  end

  assign spi_drive_o.miso = q.tx_sr[7];
  assign spi_drive_o.miso_oe = q.st == ST_READOUT && !q.sync2.cs_n;
  assign frame_available_o = q.frame_rdy;
  assign integrate_o = q.integ;
  assign zebra_pattern_o = q.zebra;
  assign threshold_o = q.thr;
  assign dummy_scan_o = q.dummy;

  ///////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_integ_end;
    $fell(q.integ);
  endsequence

  sequence s_conv_hold;
    !q.frame_rdy [*8];
  endsequence

  sequence s_start_cmd;
    start_evt;
  endsequence

  AST_POR_QUIET: assert property (q.st == ST_POR |->
    !q.integ && !q.frame_rdy && !spi_drive_o.miso_oe) // RL2
    else $error("activity during power-on reset");
  AST_WAIT_CR_ONLY: assert property (q.st == ST_WAIT_CR && cmd_done &&
    op != CHIP_RESET_COMMAND |=> q.st == ST_WAIT_CR) // RL3
    else $error("command accepted before chip reset");
  AST_START_INTEG: assert property (s_start_cmd |=>
    q.integ && q.st == ST_INTEG) // RL4
    else $error("start command did not begin integration");
  AST_CONV_WAIT: assert property (s_integ_end |-> s_conv_hold) // RL5
    else $error("frame ready before conversion wait");
  AST_READY_TIMING: assert property ($rose(q.frame_rdy) |->
    $past(q.st) == ST_CONVERT &&
    $past(q.cnt) == 16'(CONV_CYC - 1)) // RL5
    else $error("frame ready not after full conversion");
  AST_ZEBRA_CYCLE: assert property ((s_start_cmd and (zb_code != ZB_OFF))
    |=> q.zebra == $past(zb_code) &&
    q.int_ticks == ZEBRA_INT_TICKS) // RL10
    else $error("zebra command not run as frame cycle");
  AST_ZEBRA_CS_HIGH: assert property ($rose(q.integ) |->
    $past(cs_rise) && q.sync2.cs_n) // RL12
    else $error("integration began without chip select high");
  AST_TEMP_BYTE: assert property (fill_valid && temp_slot &&
    q.zebra != ZB_ALL_LOW |-> fill_data == q.temp) // RL1
    else $error("temperature byte missing from frame");
  AST_TZ0_DARK: assert property (fill_valid && temp_slot &&
    q.zebra == ZB_ALL_LOW |-> fill_data == DARK_CODE) // RL13
    else $error("all-low zebra temperature byte not dark");
  AST_READY_DROP: assert property ((q.frame_rdy and s_start_cmd)
    |=> !q.frame_rdy ##1 !q.frame_rdy) // RL14
    else $error("frame ready kept across new start");

endmodule

// ### testbench/link_host.sv
// host side of the serial command link, as a behavioural model
// assumes core_clk_i is the bench clock; link pins move on its edges
`timescale 1ns/1ps
module link_host (
  // clock
  input wire logic core_clk_i,
  // device side
  input wire frame_seq_pkg::spi_drive_s drive_i,
  input wire logic ready_i,
  // link pins
  output frame_seq_pkg::spi_pins_s pins_o
);
  import frame_seq_pkg::*;

  logic line;
  logic junk = 1'b0;
  logic [7:0] got_byte;
  event got;

  ////////////////////////////////////////////////////////////////////////////
  // released line floats: show a moving pattern, never a held bit
  always @(posedge core_clk_i) junk <= ~junk;
  assign line = drive_i.miso_oe ? drive_i.miso : junk;

  initial pins_o = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // one framed transfer; 8 core cycles per link bit, clock idles low
  task automatic frame(input int nbits, input logic [23:0] cmd,
                       input bit rd);
    @(posedge core_clk_i) pins_o.cs_n <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < nbits; i++) begin
      pins_o.mosi <= rd ? ~pins_o.mosi : cmd[23 - (i % 24)];
      repeat (4) @(posedge core_clk_i);
      pins_o.sclk <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      // sample late in the high phase, clear of the shift edge
      @(negedge core_clk_i) got_byte = {got_byte[6:0], line};
      @(posedge core_clk_i) pins_o.sclk <= 1'b0;
      if (rd && i % 8 == 7) -> got;
    end
    repeat (4) @(posedge core_clk_i);
    pins_o.cs_n <= 1'b1;
    pins_o.mosi <= ~pins_o.mosi;
    repeat (8) @(posedge core_clk_i);
  endtask

  // poll frame-ready as an interrupt stand-in before any read
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 2000 && !ok; n++) begin
      @(posedge core_clk_i);
      ok = (ready_i === 1'b1);
    end
  endtask
endmodule

// ### testbench/tb_frame_sequencer.sv
// self-checking bench of the frame sequencer with a host model
// assumes shortened counts; read-out bytes checked from a queue
`timescale 1ns/1ps
module tb_frame_sequencer;
  import frame_seq_pkg::*;

  localparam int POR_N = 10;
  localparam int CONV_N = 12;
  localparam int TICK_N = 2;
  localparam int FL = 20;

  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  spi_pins_s pins;
  spi_drive_s drv;
  logic [7:0] pixel_data_i = 8'h00;
  logic pixel_valid_i = 1'b0;
  logic pixel_ready_o;
  logic [7:0] temp_code_i = 8'h00;
  logic frame_available_o;
  logic integrate_o;
  zebra_e zebra_pattern_o;
  logic [7:0] threshold_o;
  logic dummy_scan_o;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic int_p = 1'b0;
  logic rdy_p = 1'b0;
  logic cs_p = 1'b1;
  int t_on, t_off, t_rdy, t_cs;
  int idx = 0;
  bit res8 = 1'b0;
  logic [7:0] temp_exp;
  logic [7:0] exp_q[$];
  logic [7:0] zcmd [4] = '{ZEBRA_ODD_HIGH_COMMAND, ZEBRA_EVEN_HIGH_COMMAND,
                           ZEBRA_ALL_HIGH_COMMAND, ZEBRA_ALL_LOW_COMMAND};
  zebra_e zexp [4] = '{ZB_ODD, ZB_EVEN, ZB_ALL_HIGH, ZB_ALL_LOW};

  always #25 core_clk_i = ~core_clk_i;

  frame_sequencer #(.POR_CYC(POR_N), .CONV_CYC(CONV_N), .TICK_CYC(TICK_N),
                    .FRAME_LEN(FL)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .spi_pins_i(pins),
    .spi_drive_o(drv), .pixel_data_i(pixel_data_i),
    .pixel_valid_i(pixel_valid_i), .pixel_ready_o(pixel_ready_o),
    .temp_code_i(temp_code_i), .frame_available_o(frame_available_o),
    .integrate_o(integrate_o), .zebra_pattern_o(zebra_pattern_o),
    .threshold_o(threshold_o), .dummy_scan_o(dummy_scan_o));

  link_host host (.core_clk_i(core_clk_i), .drive_i(drv),
                  .ready_i(frame_available_o), .pins_o(pins));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // edge times of the sequence, plus the hang limit
  always @(posedge core_clk_i) begin
    cyc++;
    if (integrate_o === 1'b1 && int_p === 1'b0) t_on = cyc;
    if (integrate_o === 1'b0 && int_p === 1'b1) t_off = cyc;
    if (frame_available_o === 1'b1 && rdy_p === 1'b0) t_rdy = cyc;
    if (pins.cs_n === 1'b1 && cs_p === 1'b0) t_cs = cyc;
    int_p <= integrate_o;
    rdy_p <= frame_available_o;
    cs_p <= pins.cs_n;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end

  // pixel source; each taken byte becomes an expected frame byte
  always @(posedge core_clk_i) begin
    pixel_valid_i <= rst_n_i && ($urandom % 4) != 0;
    if (pixel_valid_i && pixel_ready_o) begin
      if (idx == 6 && res8) begin
        exp_q.push_back(temp_exp);
        idx++;
      end
      if (idx < FL) exp_q.push_back(pixel_data_i);
      idx++;
      pixel_data_i <= $urandom;
    end
  end

  always @(host.got) begin
    chk("frame byte", exp_q.size() ? exp_q.pop_front() : 8'hxx,
        host.got_byte);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic start_run(input logic [23:0] cmd, input int len);
    bit ok;
    host.frame(24, cmd, 1'b0);
    host.wait_ready(ok);
    // let the edge recorder run first: it shares the edge with the poll
    @(posedge core_clk_i);
    chk("ready seen", 1, ok);
    chk("start after cs rise", 1, t_on > t_cs);
    chk("integration length", 1,
        (t_off - t_on >= len - TICK_N) && (t_off - t_on <= len + TICK_N));
    chk("conversion wait", CONV_N, t_rdy - t_off);
  endtask

  task automatic read_out(input bit r8, input bit dark);
    logic [7:0] t;
    t = $urandom;
    @(posedge core_clk_i) temp_code_i <= t;
    temp_exp = dark ? DARK_CODE : t;
    res8 = r8;
    idx = 0;
    host.frame(24, {READ_OUT_COMMAND, 7'h00, r8, 8'h00}, 1'b0);
    host.frame(FL * 8, 24'h000000, 1'b1);
    chk("ready after read", 0, frame_available_o);
    chk("line released", 0, drv.miso_oe);
  endtask

  initial begin
    logic [7:0] thr;
    bit ok;
    void'($urandom(32'hEC92));
    repeat (11) @(posedge core_clk_i);
    chk("dummy in reset", 1, dummy_scan_o);
    chk("ready in reset", 0, frame_available_o);
    @(posedge core_clk_i) rst_n_i <= 1'b1;
    repeat (POR_N + 5) @(posedge core_clk_i);
    host.frame(24, {START_INT_COMMAND, 16'h0003}, 1'b0);
    repeat (20) @(posedge core_clk_i);
    chk("start before chip reset", 0, integrate_o);
    host.frame(24, {CHIP_RESET_COMMAND, 16'h0000}, 1'b0);
    thr = $urandom;
    host.frame(24, {WRITE_THRESHOLD_COMMAND, thr, 8'h00}, 1'b0);
    chk("threshold", thr, threshold_o);
    start_run({START_INT_COMMAND, 16'h0003}, 3 * TICK_N);
    chk("dummy before read", 1, dummy_scan_o);
    read_out(1'b0, 1'b0);
    chk("dummy after read", 0, dummy_scan_o);
    for (int i = 0; i < 4; i++) begin
      start_run({zcmd[i], 16'h0000}, 16 * TICK_N);
      chk("zebra kind", zexp[i], zebra_pattern_o);
      if (i == 0) begin
        // deliberate early restart while a frame is pending
        host.frame(24, {START_INT_COMMAND, 16'h0002}, 1'b0);
        chk("ready drops on restart", 0, frame_available_o);
        host.wait_ready(ok);
        chk("ready after restart", 1, ok);
      end
      read_out(1'b1, i == 3);
    end
    chk("bytes left", 0, exp_q.size());
    test_done();
  end
endmodule
